// File: flash_read_wait_state_count_map_defs.vh
// Behaviour
// R1 - one megabyte main array reachable by reads
// R2 - every array read fetches one 128-bit line
// R3 - byte to double-word writes, sector and mass erase
// R4 - twelve sectors: 4x16K, 1x64K, 7x128K ascending
// R5 - sector 0 at 0x08000000-0x08003fff, 16K steps
// R6 - sector 4 at 0x08010000-0x0801ffff
// R7 - sector 5 at 0x08020000-0x0803ffff, then contiguous
// R8 - sector 11 at 0x080e0000-0x080fffff
// R9 - boot area decoded and write protected
// R10 - 512 otp bytes plus 16 lock bytes
// R11 - 16-byte option area ending at 0x1fffc00f
// R12 - array read takes wait states plus one
// R13 - software picks wait states, upper supply ranges
// R14 - software picks wait states, lower supply ranges
// R15 - wait-state count is zero after reset
// R16 - software keeps prefetch off below 2.1 V
// R17 - raise clock: write wait states, confirm, then clock
// R18 - access control readback shows effective wait states
// R19 - lower clock: clock first, then wait states
// R20 - new wait states apply later, readback effective
// R21 - decoder gives sector index and region selects
`ifndef FLASH_READ_WAIT_STATE_COUNT_MAP_DEFS_VH
`define FLASH_READ_WAIT_STATE_COUNT_MAP_DEFS_VH

// address map
`define MAIN_BASE       32'h0800_0000
`define MAIN_LAST       32'h080f_ffff
`define BOOT_BASE       32'h1fff_0000
`define BOOT_LAST       32'h1fff_77ff
`define OTP_BASE        32'h1fff_7800
`define OTP_LAST        32'h1fff_7a0f
`define OPT_BASE        32'h1fff_c000
`define OPT_LAST        32'h1fff_c00f

// sector layout inside the main array offset
`define SMALL_SECTORS   4'h4
`define BIG_SECTOR      4'h4
`define LAST_SECTOR     4'hb
`define OFFSET_W        20

// region codes towards the array
`define REGION_MAIN     2'h0
`define REGION_BOOT     2'h1
`define REGION_OTP      2'h2
`define REGION_OPT      2'h3

// access sizes
`define SIZE_BYTE       2'h0
`define SIZE_HALF       2'h1
`define SIZE_WORD       2'h2
`define SIZE_DWORD      2'h3

// register offsets on the register bus
`define REG_ACCESS_CTRL 12'h000
`define REG_ERASE_CMD   12'h004
`define REG_STATUS      12'h008

// field positions
`define WS_MSB          2
`define WS_RESET        3'h0
`define CMD_SECTOR_BIT  0
`define CMD_MASS_BIT    1
`define CMD_SECT_LSB    8
`define CMD_SECT_MSB    11
`define STAT_BUSY_BIT   0
`define STAT_WPROT_BIT  1
`define STAT_REJECT_BIT 2

`endif

// File: sector_decode.v
`timescale 1ns/100ps
`default_nettype none
`include "flash_read_wait_state_count_map_defs.vh"

// combinational decode of a bus address into region and sector
module sector_decode (
    // address in
    input  wire [31:0] addr_i,
    // decode out
    output reg         main_sel_o,
    output reg         boot_sel_o,
    output reg         otp_sel_o,
    output reg         opt_sel_o,
    output reg  [3:0]  sector_o,
    output reg  [19:0] offset_o
);

    reg [31:0] rel; // address relative to the main base
    reg [31:0] sub; // address relative to a system region base

    // region selects, sector index and in-region offset
    always @* begin
        rel        = addr_i - `MAIN_BASE;
        main_sel_o = (addr_i >= `MAIN_BASE) && (addr_i <= `MAIN_LAST); // R1
        boot_sel_o = (addr_i >= `BOOT_BASE) && (addr_i <= `BOOT_LAST); // R9
        otp_sel_o  = (addr_i >= `OTP_BASE) && (addr_i <= `OTP_LAST);   // R10
        opt_sel_o  = (addr_i >= `OPT_BASE) && (addr_i <= `OPT_LAST);   // R11
        sub        = rel;
        if (boot_sel_o) begin
            sub = addr_i - `BOOT_BASE;
        end else if (otp_sel_o) begin
            sub = addr_i - `OTP_BASE;
        end else if (opt_sel_o) begin
            sub = addr_i - `OPT_BASE;
        end
        // regions stay below one megabyte, so the upper bits are dropped on purpose
        offset_o   = sub[19:0];
        // sector index: four small, one mid, seven large
        if (rel[19:16] == 4'h0) begin
            sector_o = {2'b00, rel[15:14]}; // R5
        end else if (rel[19:16] == 4'h1) begin
            sector_o = `BIG_SECTOR; // R6
        end else begin
            sector_o = `SMALL_SECTORS + {1'b0, rel[19:17]}; // R7 R8
        end
        if (!main_sel_o) begin
            sector_o = 4'h0; // R21
        end
    end

endmodule
`default_nettype wire

// File: flash_read_wait_state_count_map.v
`timescale 1ns/100ps
`default_nettype none
`include "flash_read_wait_state_count_map_defs.vh"

// read side controller of the embedded array: decode, wait states,
// program and erase launch, and an apb register slave
module flash_read_wait_state_count_map #(
    parameter WS_W   = 3,   // wait-state field width, up to seven
    parameter LINE_W = 128  // width of one array line
) (
    // clock and reset
    input  wire              clk_i,
    input  wire              rst_n_i,
    // apb register slave
    input  wire              psel_i,
    input  wire              penable_i,
    input  wire              pwrite_i,
    input  wire [11:0]       paddr_i,
    input  wire [31:0]       pwdata_i,
    output reg  [31:0]       prdata_o,
    output reg               pready_o,
    output reg               pslverr_o,
    // cpu read and write port
    input  wire              cpu_req_i,
    input  wire              cpu_we_i,
    input  wire [31:0]       cpu_addr_i,
    input  wire [1:0]        cpu_size_i,
    input  wire [63:0]       cpu_wdata_i,
    output reg               cpu_ack_o,
    output reg               cpu_err_o,
    output reg  [31:0]       cpu_rdata_o,
    // array macro side
    output reg               arr_rd_o,
    output reg               arr_wr_o,
    output reg               arr_erase_o,
    output reg               arr_mass_o,
    output reg  [1:0]        arr_region_o,
    output reg  [3:0]        arr_sector_o,
    output reg  [19:0]       arr_offset_o,
    output reg  [1:0]        arr_size_o,
    output reg  [63:0]       arr_wdata_o,
    input  wire [LINE_W-1:0] arr_line_i,
    input  wire              arr_done_i
);

    // controller states
    localparam ST_IDLE  = 2'h0;
    localparam ST_READ  = 2'h1;
    localparam ST_WRITE = 2'h2;
    localparam ST_ERASE = 2'h3;

    reg  [1:0]      state;      // controller state
    reg  [WS_W-1:0] ws_req;     // wait states as last written
    reg  [WS_W-1:0] ws_eff;     // wait states in use for array reads
    reg  [WS_W-1:0] ws_cnt;     // remaining wait states of a read
    reg             wprot_flag; // sticky: refused write to boot area
    reg             rej_flag;   // sticky: refused erase command

    // decoder outputs
    wire            main_sel;
    wire            boot_sel;
    wire            otp_sel;
    wire            opt_sel;
    wire [3:0]      sector;
    wire [19:0]     offset;

    // apb qualifiers
    wire            apb_setup;  // setup phase of a transfer
    wire            apb_wr;     // write taking effect this edge
    wire            reg_hit;    // address matches a register

    // cpu request qualifiers
    wire            cpu_take;   // request accepted this edge
    wire            any_sel;    // address lands in a mapped region

    // erase command fields
    wire            cmd_sector; // sector erase requested
    wire            cmd_mass;   // mass erase requested
    wire [3:0]      cmd_sect;   // sector to erase
    wire            cmd_ok;     // command legal now

    reg  [31:0]     next_prdata; // read mux for the register bus
    reg  [31:0]     line_word;   // word picked out of the array line

    // address decoder
    sector_decode u_decode (
        .addr_i     (cpu_addr_i),
        .main_sel_o (main_sel),
        .boot_sel_o (boot_sel),
        .otp_sel_o  (otp_sel),
        .opt_sel_o  (opt_sel),
        .sector_o   (sector),
        .offset_o   (offset)
    );

    assign apb_setup  = psel_i & ~penable_i;
    assign apb_wr     = psel_i & penable_i & pready_o & pwrite_i;
    assign reg_hit    = (paddr_i == `REG_ACCESS_CTRL) || (paddr_i == `REG_ERASE_CMD) ||
                        (paddr_i == `REG_STATUS);
    assign any_sel    = main_sel | boot_sel | otp_sel | opt_sel;
    // the ack/err cycle still sees the old request, so it is not retaken
    assign cpu_take   = (state == ST_IDLE) & cpu_req_i & ~cpu_ack_o & ~cpu_err_o;
    assign cmd_sector = pwdata_i[`CMD_SECTOR_BIT];
    assign cmd_mass   = pwdata_i[`CMD_MASS_BIT];
    assign cmd_sect   = pwdata_i[`CMD_SECT_MSB:`CMD_SECT_LSB];
    // an erase is taken only while idle with no cpu request taken; a sector erase also needs a real sector number
    assign cmd_ok     = (state == ST_IDLE) & ~cpu_take & (cmd_mass | (cmd_sect <= `LAST_SECTOR));

    // pick the addressed 32-bit word out of the 128-bit line
    always @* begin
        case (arr_offset_o[3:2])
            2'h0:    line_word = arr_line_i[31:0];   // R2
            2'h1:    line_word = arr_line_i[63:32];
            2'h2:    line_word = arr_line_i[95:64];
            2'h3:    line_word = arr_line_i[127:96];
            default: line_word = 32'h0000_0000;
        endcase
    end

    // register read mux
    always @* begin
        next_prdata = 32'h0000_0000;
        case (paddr_i)
            `REG_ACCESS_CTRL: begin
                next_prdata[`WS_MSB:0] = ws_eff; // R18 R20
            end
            `REG_STATUS: begin
                next_prdata[`STAT_BUSY_BIT]   = (state != ST_IDLE);
                next_prdata[`STAT_WPROT_BIT]  = wprot_flag;
                next_prdata[`STAT_REJECT_BIT] = rej_flag;
            end
            default: begin
                next_prdata = 32'h0000_0000; // erase command reads as zero
            end
        endcase
    end

    // apb answer: ready and data registered in the setup cycle
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= apb_setup;
            pslverr_o <= apb_setup & ~reg_hit;
            if (apb_setup && !pwrite_i) begin
                prdata_o <= next_prdata;
            end
        end
    end

    // wait-state setting: written value, applied only between reads
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ws_req <= `WS_RESET; // R15
            ws_eff <= `WS_RESET; // R15
        end else begin
            if (apb_wr && paddr_i == `REG_ACCESS_CTRL) begin
                ws_req <= pwdata_i[`WS_MSB:0];
            end
            // never change the count under a read in flight
            if (state == ST_IDLE && !cpu_take) begin
                ws_eff <= ws_req; // R20
            end
        end
    end

    // sticky status flags: hardware set wins over write-one clear
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wprot_flag <= 1'b0;
            rej_flag   <= 1'b0;
        end else begin
            if (cpu_take && cpu_we_i && boot_sel) begin
                wprot_flag <= 1'b1; // R9
            end else if (apb_wr && paddr_i == `REG_STATUS && pwdata_i[`STAT_WPROT_BIT]) begin
                wprot_flag <= 1'b0;
            end
            if (apb_wr && paddr_i == `REG_ERASE_CMD && (cmd_sector || cmd_mass) && !cmd_ok) begin
                rej_flag <= 1'b1;
            end else if (apb_wr && paddr_i == `REG_STATUS && pwdata_i[`STAT_REJECT_BIT]) begin
                rej_flag <= 1'b0;
            end
        end
    end

    // main controller: reads with wait states, writes, erases
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state        <= ST_IDLE;
            ws_cnt       <= {WS_W{1'b0}};
            cpu_ack_o    <= 1'b0;
            cpu_err_o    <= 1'b0;
            cpu_rdata_o  <= 32'h0000_0000;
            arr_rd_o     <= 1'b0;
            arr_wr_o     <= 1'b0;
            arr_erase_o  <= 1'b0;
            arr_mass_o   <= 1'b0;
            arr_region_o <= `REGION_MAIN;
            arr_sector_o <= 4'h0;
            arr_offset_o <= 20'h0_0000;
            arr_size_o   <= `SIZE_BYTE;
            arr_wdata_o  <= 64'h0000_0000_0000_0000;
        end else begin
            // strobes last one cycle
            cpu_ack_o   <= 1'b0;
            cpu_err_o   <= 1'b0;
            arr_rd_o    <= 1'b0;
            arr_wr_o    <= 1'b0;
            arr_erase_o <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (cpu_take) begin
                        if (!any_sel || (cpu_we_i && boot_sel)) begin
                            // unmapped address or protected boot area
                            cpu_err_o <= 1'b1; // R9
                        end else begin
                            // latch the decoded target for the array
                            arr_sector_o <= sector; // R21
                            arr_offset_o <= offset;
                            arr_size_o   <= cpu_size_i;
                            arr_wdata_o  <= cpu_wdata_i;
                            if (boot_sel) begin
                                arr_region_o <= `REGION_BOOT;
                            end else if (otp_sel) begin
                                arr_region_o <= `REGION_OTP; // R10
                            end else if (opt_sel) begin
                                arr_region_o <= `REGION_OPT; // R11
                            end else begin
                                arr_region_o <= `REGION_MAIN; // R4
                            end
                            if (cpu_we_i) begin
                                arr_wr_o <= 1'b1; // R3
                                state    <= ST_WRITE;
                            end else begin
                                arr_rd_o <= 1'b1;
                                ws_cnt   <= ws_eff; // R12
                                state    <= ST_READ;
                            end
                        end
                    end else if (apb_wr && paddr_i == `REG_ERASE_CMD && (cmd_sector || cmd_mass) && cmd_ok) begin
                        // sector or whole-array erase
                        arr_erase_o  <= 1'b1; // R3
                        arr_mass_o   <= cmd_mass;
                        arr_sector_o <= cmd_sect;
                        arr_region_o <= `REGION_MAIN;
                        state        <= ST_ERASE;
                    end
                end
                ST_READ: begin
                    // line sampled once the wait states have elapsed
                    if (ws_cnt == {WS_W{1'b0}}) begin
                        cpu_rdata_o <= line_word; // R12
                        cpu_ack_o   <= 1'b1;
                        state       <= ST_IDLE;
                    end else begin
                        ws_cnt <= ws_cnt - {{(WS_W-1){1'b0}}, 1'b1};
                    end
                end
                ST_WRITE: begin
                    // reads stall until the program operation ends
                    if (arr_done_i) begin
                        cpu_ack_o <= 1'b1;
                        state     <= ST_IDLE;
                    end
                end
                ST_ERASE: begin
                    if (arr_done_i) begin
                        arr_mass_o <= 1'b0;
                        state      <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// File: flash_read_wait_state_count_map_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "flash_read_wait_state_count_map_defs.vh"

// port checks of the read-wait_state_count map controller
module flash_read_wait_state_count_map_assertions (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    // apb side
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic [11:0] paddr_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // cpu side
    input wire logic        cpu_req_i,
    input wire logic        cpu_we_i,
    input wire logic [31:0] cpu_addr_i,
    input wire logic        cpu_ack_o,
    input wire logic        cpu_err_o,
    // array side
    input wire logic        arr_rd_o,
    input wire logic        arr_wr_o,
    input wire logic        arr_mass_o,
    input wire logic        arr_done_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // request in the boot area
    wire boot = cpu_addr_i >= `BOOT_BASE && cpu_addr_i <= `BOOT_LAST;
    // request in any decoded area
    wire hit = boot || (cpu_addr_i >= `MAIN_BASE && cpu_addr_i <= `MAIN_LAST)
        || (cpu_addr_i >= `OTP_BASE && cpu_addr_i <= `OTP_LAST)
        || (cpu_addr_i >= `OPT_BASE && cpu_addr_i <= `OPT_LAST);
    // request still waiting for its answer
    wire pend = cpu_req_i && !cpu_ack_o && !cpu_err_o;

    chk_pready_setup: assert property (psel_i && !penable_i |=> pready_o)
        else $error("pready missing after setup");
    chk_pready_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    chk_slverr_map: assert property (psel_i && !penable_i |=> pslverr_o == !($past(paddr_i) == `REG_ACCESS_CTRL || $past(paddr_i) == `REG_ERASE_CMD || $past(paddr_i) == `REG_STATUS))
        else $error("pslverr wrong for address");
    chk_ack_pulse: assert property (cpu_ack_o |=> !cpu_ack_o)
        else $error("ack longer than one cycle");
    chk_rd_wait_state_count: assert property (arr_rd_o |-> ##[1:8] cpu_ack_o)
        else $error("read not answered within seven waits");
    chk_boot_err: assert property (pend && cpu_we_i && boot |-> ##[1:300] cpu_err_o)
        else $error("boot write not refused");
    chk_boot_noprog: assert property (cpu_req_i && cpu_we_i && boot |=> !arr_wr_o)
        else $error("boot write reached the array");
    chk_unmapped_err: assert property (pend && !hit |-> ##[1:300] cpu_err_o)
        else $error("unmapped access not refused");
    chk_mass_hold: assert property (arr_mass_o && !arr_done_i |=> arr_mass_o)
        else $error("mass erase dropped early");
    chk_reset_quiet: assert property (!$past(rst_n_i) |-> !pready_o && !cpu_ack_o && !arr_rd_o)
        else $error("outputs active after reset");

    // main scenarios reached
    cover property (arr_rd_o ##[1:7] cpu_ack_o);
    cover property (cpu_err_o);
    cover property (arr_mass_o && arr_done_i);
endmodule

bind flash_read_wait_state_count_map flash_read_wait_state_count_map_assertions u_chk (
    .clk_i, .rst_n_i, .psel_i, .penable_i, .paddr_i, .pready_o, .pslverr_o,
    .cpu_req_i, .cpu_we_i, .cpu_addr_i, .cpu_ack_o, .cpu_err_o,
    .arr_rd_o, .arr_wr_o, .arr_mass_o, .arr_done_i
);
`default_nettype wire

// File: flash_array_model.sv
`timescale 1ns/100ps
`default_nettype none

// behavioural array macro: lines on read, done after a set delay
module flash_array_model (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // requests from the controller
    input  wire logic        rd_i,
    input  wire logic        wr_i,
    input  wire logic        erase_i,
    input  wire logic [1:0]  region_i,
    input  wire logic [3:0]  sector_i,
    input  wire logic [19:0] offset_i,
    // program and erase time in cycles
    input  wire logic [7:0]  dly_i,
    // answers
    output logic [127:0]     line_o,
    output logic             done_o
);
    logic [31:0]  held; // pattern of the last line read
    logic [3:0]   age;  // edges since that read
    logic [7:0]   left; // cycles until program or erase ends
    logic [31:0]  w;    // pattern now on the line
    logic [127:0] line; // four words of one line
    // pattern carries region, sector and line offset
    assign w = rd_i ? {8'ha5, region_i, (region_i == 2'h0) ? sector_i : 4'h0, offset_i[19:4], 2'h0} : held;
    assign line = {w | 32'h3, w | 32'h2, w | 32'h1, w};
    // past the hold time the line shows the inverse
    assign line_o = (rd_i || age < 4'h9) ? line : ~line;

    // read hold and program or erase timer
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            held <= 32'h0;
            age <= 4'hf;
            left <= 8'h0;
            done_o <= 1'b0;
        end else begin
            done_o <= (left == 8'h1);
            if (rd_i) begin
                held <= w;
                age <= 4'h0;
            end else if (age != 4'hf) begin
                age <= age + 4'h1;
            end
            if (wr_i || erase_i) begin
                left <= dly_i;
            end else if (left != 8'h0) begin
                left <= left - 8'h1;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "flash_read_wait_state_count_map_defs.vh"

// self-checking bench of the read-wait_state_count map controller
module tb;
    logic clk_i = 1'b0, rst_n_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h0;
    logic [31:0] pwdata_i = 32'h0, cpu_addr_i = 32'h0;
    logic cpu_req_i = 1'b0, cpu_we_i = 1'b0;
    logic [1:0] cpu_size_i = 2'h0;
    logic [63:0] cpu_wdata_i = 64'h0;
    logic [7:0] dly = 8'h2; // array busy time
    wire [31:0] prdata_o, cpu_rdata_o;
    wire pready_o, pslverr_o, cpu_ack_o, cpu_err_o, arr_done_i;
    wire arr_rd_o, arr_wr_o, arr_erase_o, arr_mass_o;
    wire [1:0] arr_region_o, arr_size_o;
    wire [3:0] arr_sector_o;
    wire [19:0] arr_offset_o;
    wire [63:0] arr_wdata_o;
    wire [127:0] arr_line_i;
    int num_errors = 0, compares = 0, cycles = 0, seed = 64666, n;
    logic [31:0] q, a;
    logic e;
    // sector and region edges
    logic [31:0] corner [17] = '{32'h0800_0000, 32'h0800_3ffc, 32'h0800_4000, 32'h0800_fffc,
        32'h0801_0000, 32'h0801_fffc, 32'h0802_0000, 32'h0803_fffc, 32'h0804_0000, 32'h080e_0000,
        32'h080f_fffc, 32'h1fff_0000, 32'h1fff_77fc, 32'h1fff_7800, 32'h1fff_7a0c, 32'h1fff_c000,
        32'h1fff_c00c};
    logic [31:0] bad [4] = '{32'h0810_0000, 32'h1fff_7a10, 32'h1fff_c010, 32'h07ff_fffc};

    flash_read_wait_state_count_map dut (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .cpu_req_i, .cpu_we_i, .cpu_addr_i,
        .cpu_size_i, .cpu_wdata_i, .cpu_ack_o, .cpu_err_o, .cpu_rdata_o, .arr_rd_o, .arr_wr_o,
        .arr_erase_o, .arr_mass_o, .arr_region_o, .arr_sector_o, .arr_offset_o, .arr_size_o,
        .arr_wdata_o, .arr_line_i, .arr_done_i);
    flash_array_model u_arr (.clk_i, .rst_n_i, .rd_i(arr_rd_o), .wr_i(arr_wr_o),
        .erase_i(arr_erase_o), .region_i(arr_region_o), .sector_i(arr_sector_o),
        .offset_i(arr_offset_o), .dly_i(dly), .line_o(arr_line_i), .done_o(arr_done_i));

    always #2.5 clk_i = ~clk_i;
    // hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    // compare and count
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer, released after pready
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= ad;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (!pready_o);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // one cpu request held until answered; n counts edges; plain fetches, no prefetch ahead
    task automatic cpu(input logic we, input logic [31:0] ad, input logic [1:0] sz);
        @(posedge clk_i);
        cpu_req_i <= 1'b1;
        cpu_we_i <= we;
        cpu_addr_i <= ad;
        cpu_size_i <= sz;
        cpu_wdata_i <= {$random(seed), $random(seed)};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (!(cpu_ack_o || cpu_err_o));
        e = cpu_err_o;
        q = cpu_rdata_o;
        cpu_req_i <= 1'b0;
    endtask

    // expected word from region, sector and offset
    function automatic logic [31:0] exp_word(input logic [31:0] ad);
        logic [31:0] off;
        logic [1:0] r;
        logic [3:0] s;
        off = ad - `MAIN_BASE;
        r = `REGION_MAIN;
        s = off < 32'h1_0000 ? {2'b0, off[15:14]} : off < 32'h2_0000 ? 4'h4 : 4'h4 + off[19:17];
        if (ad >= `BOOT_BASE) begin
            r = `REGION_BOOT;
            off = ad - `BOOT_BASE;
        end
        if (ad >= `OTP_BASE) begin
            r = `REGION_OTP;
            off = ad - `OTP_BASE;
        end
        if (ad >= `OPT_BASE) begin
            r = `REGION_OPT;
            off = ad - `OPT_BASE;
        end
        if (r != `REGION_MAIN) s = 4'h0;
        return {8'ha5, r, s, off[19:4], ad[3:2]};
    endfunction

    // closing report
    task automatic tally_and_finish();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        apb(1'b0, `REG_ACCESS_CTRL, 32'h0);
        check(q, 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        check({q, e}, 33'h0_0000_0001);
        for (int ws = 0; ws < 8; ws++) begin
            // new count first, confirmed before reading
            apb(1'b1, `REG_ACCESS_CTRL, ws);
            repeat (2) @(posedge clk_i);
            apb(1'b0, `REG_ACCESS_CTRL, 32'h0);
            check(q[2:0], ws[2:0]);
            for (int i = 0; i < 21; i++) begin
                a = i < 17 ? corner[i] : `MAIN_BASE + ($random(seed) & 32'h000f_fffc);
                cpu(1'b0, a, `SIZE_WORD);
                check(n, ws + 3);
                check({e, q}, {1'b0, exp_word(a)});
            end
        end
        // lowering: the smaller count written, then confirmed
        apb(1'b1, `REG_ACCESS_CTRL, 32'h0);
        repeat (2) @(posedge clk_i);
        apb(1'b0, `REG_ACCESS_CTRL, 32'h0);
        check(q[2:0], 3'h0);
        foreach (bad[i]) begin
            cpu(1'b0, bad[i], `SIZE_WORD);
            check(e, 1'b1);
        end
        for (int sz = 0; sz < 4; sz++) begin
            dly <= sz[0] ? 8'd20 : 8'd2;
            cpu(1'b1, `MAIN_BASE + ($random(seed) & 32'h000f_fff8), sz[1:0]);
            check({e, n > (sz[0] ? 20 : 2)}, 2'b01);
        end
        cpu(1'b1, `BOOT_BASE + 32'h100, `SIZE_WORD);
        check(e, 1'b1);
        apb(1'b0, `REG_STATUS, 32'h0);
        check(q[2:0], 3'b010);
        apb(1'b1, `REG_STATUS, 32'h6);
        foreach (bad[i]) begin
            apb(1'b1, `REG_ERASE_CMD, i < 2 ? 32'h0000_0b01 + i : 32'h0000_0c01);
            apb(1'b0, `REG_STATUS, 32'h0);
            check(q[2:0], i < 2 ? 3'b001 : 3'b100);
            repeat (30) @(posedge clk_i);
            apb(1'b1, `REG_STATUS, 32'h6);
            apb(1'b0, `REG_STATUS, 32'h0);
            check(q[2:0], 3'b000);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
